// >>> hdl/switch_ctrl_map.vh
// switch_ctrl_map.vh: offsets, field positions, reset values, timing counts
// assumes a 20 MHz aclk; included by the switch_ctrl module and the test bench
//
// Functional notes
// - watchdog: enable high too long turns off
// - enable rising edge restarts watchdog count
// - enable falling edge clears fault flags; a live shutdown cause keeps its flag set
// - pulses over 20 us may start turnoff
// - watchdog only in watchdog variant
// - enable and diag low: standby delay
// - still low after delay: enter standby
// - standby: no diagnostics, lowest power
// - diagnostic state: diagnostics, switch off
// - active: switch on, diagnostics switchable
// - protective shutdown enters fault state
// - leave fault: clear, latch low, retry done
// - after fault, switch follows enable
// - ground loss forces switch off
// - reverse current changes nothing
// - fault pin: shutdown always, open load sel 00
// - open load tracked; cleared on edges
`ifndef SWITCH_CTRL_MAP_VH
`define SWITCH_CTRL_MAP_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_WD_TIMEOUT 4'h8
`define REG_STBY_DELAY 4'hc
`define REG_RETRY 4'h0 + 4'h0

// ctrl fields
`define CTRL_WD_VARIANT 0
`define CTRL_RST 32'h0000_0001

// ---------------------------------------------------------------
// time base: 1 us tick from the 50 ns clock
// ---------------------------------------------------------------
`define CLK_NS 50
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
// last divider count, TICK_CYCLES - 1 at the divider's width
`define TICK_LAST 5'h13
// timeouts in microseconds (register reset values)
`define WD_TIMEOUT_US 32'h0000_03e8
`define STBY_DELAY_US 32'h0000_03e8
`define RETRY_US 32'h0000_03e8

// state codes, one-hot
`define ST_STBY_DLY 6'h01
`define ST_STBY 6'h02
`define ST_DIAG 6'h04
`define ST_ACTIVE 6'h08
`define ST_FAULT 6'h10
`define ST_GNDLOSS 6'h20

`endif

// >>> hdl/sync2.v
// sync2.v: two flip-flop synchroniser for a bundle of pin levels
// assumes aclk domain; inputs asynchronous
`timescale 1ns/1ns
module sync2 #(
  parameter W = 1
)(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // levels
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q; // first stage, read only by q

  // ---------------------------------------------------------------
  // two stage capture
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sync2

// >>> hdl/us_timer.v
// us_timer.v: down counter of microsecond ticks, done when it reaches zero
// assumes a tick enable from the shared time base
`timescale 1ns/1ns
module us_timer (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire tick,
  input wire load,
  input wire [31:0] value,
  // status
  output wire done
);
  reg [31:0] cnt_q; // remaining microseconds

  // ---------------------------------------------------------------
  // load wins over counting so a restart is never lost
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    // start full so no timer reads as expired right after reset
    if (!aresetn)
      cnt_q <= value;
    else if (load)
      cnt_q <= value;
    else if (tick && cnt_q != 32'h0000_0000)
      cnt_q <= cnt_q - 32'h0000_0001;
  end

  assign done = (cnt_q == 32'h0000_0000);
endmodule // us_timer

// >>> hdl/switch_ctrl.v
// switch_ctrl.v: enable watchdog and functional state machine of a
// high-side switch, with an axi4-lite register slave
// assumes pins arrive asynchronous to aclk; analog sensing gives levels
`timescale 1ns/1ns
`include "switch_ctrl_map.vh"
module switch_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // host pins
  input wire enable_in,
  input wire diag_request,
  input wire latch_sel,
  input wire [1:0] sense_select,
  // analog sensing levels
  input wire thermal_sd,
  input wire current_limit,
  input wire energy_limit,
  input wire active_ilim,
  input wire open_load_det,
  input wire gnd_lost,
  input wire reverse_current,
  // outputs
  output reg switch_on,
  output reg diag_active,
  output reg low_power,
  output wire fault_flag_n_o,
  output wire fault_flag_n_oe,
  output reg sense_fault_level
);
  // ---------------------------------------------------------------
  // synchronise pins
  // ---------------------------------------------------------------
  wire [10:0] pins_s; // synchronised pin levels
  sync2 #(.W(11)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({enable_in, diag_request, latch_sel, thermal_sd, current_limit,
        energy_limit, active_ilim, open_load_det, gnd_lost,
        sense_select}),
    .q(pins_s)
  );
  wire en_s = pins_s[10];
  wire diag_s = pins_s[9];
  wire latch_s = pins_s[8];
  wire prot_s = pins_s[7] | pins_s[6] | pins_s[5]; // shutdown causes
  wire ilim_s = pins_s[4];
  wire ol_s = pins_s[3];
  wire gnd_s = pins_s[2];
  wire [1:0] sel_s = pins_s[1:0];
  // reverse current is deliberately ignored: no logic reads it
  wire unused_rev = reverse_current;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [31:0] ctrl_q; // bit 0 selects the watchdog variant
  reg [31:0] wd_to_q; // watchdog timeout, microseconds
  reg [31:0] stby_q; // standby delay, microseconds
  reg [31:0] retry_q; // retry interval, microseconds
  reg en_d1_q; // previous enable level for edge detect
  reg diag_d1_q; // previous diag level
  reg [5:0] state_q; // one-hot state
  reg [5:0] state_d;
  reg wd_trip_q; // watchdog turned the switch off
  reg ol_flag_q; // open-load / short-to-battery indication
  reg shut_flag_q; // switch shutdown indication
  reg [4:0] tick_cnt_q; // time base divider
  reg tick_q; // one-cycle microsecond enable

  wire en_rise = en_s & ~en_d1_q;
  wire en_fall = ~en_s & en_d1_q;
  wire diag_fall = ~diag_s & diag_d1_q;
  wire wd_on = ctrl_q[`CTRL_WD_VARIANT];

  // ---------------------------------------------------------------
  // free-running microsecond time base
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == `TICK_LAST)
    begin
      tick_cnt_q <= 5'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 5'h01;
      tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // timers: watchdog, standby delay, retry
  // ---------------------------------------------------------------
  wire wd_done;
  wire stby_done;
  wire retry_done;
  // restart on every enable rising edge, hold loaded while low
  us_timer u_wd (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_q),
    .load(en_rise | ~en_s),
    .value(wd_to_q),
    .done(wd_done)
  );
  // loaded while not in standby delay
  us_timer u_stby (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_q),
    .load(state_q != `ST_STBY_DLY),
    .value(stby_q),
    .done(stby_done)
  );
  // loaded while the shutdown cause persists or outside fault
  us_timer u_retry (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_q),
    .load(state_q != `ST_FAULT || prot_s),
    .value(retry_q),
    .done(retry_done)
  );

  // ---------------------------------------------------------------
  // watchdog trip: only in the watchdog variant
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
      wd_trip_q <= 1'b0;
    else if (!wd_on)
      wd_trip_q <= 1'b0;
    else if (en_s && wd_done)
      wd_trip_q <= 1'b1;
    else if (en_rise || !en_s)
      wd_trip_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // fault indications; shutdown set wins over clear, open-load clear wins over set
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_d1_q <= 1'b0;
      diag_d1_q <= 1'b0;
      ol_flag_q <= 1'b0;
      shut_flag_q <= 1'b0;
    end
    else
    begin
      en_d1_q <= en_s;
      diag_d1_q <= diag_s;
      // edges clear first: tracking would re-latch the level while
      // the switch has not yet closed after an enable rise
      if (diag_fall || en_rise || en_fall)
        ol_flag_q <= 1'b0;
      // open load only seen with switch off and diagnostics on
      else if (!switch_on && diag_s && state_q != `ST_FAULT)
        ol_flag_q <= ol_s;
      if (prot_s)
        shut_flag_q <= 1'b1;
      else if (en_fall)
        shut_flag_q <= 1'b0;
      else if (state_q != `ST_FAULT)
        shut_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // functional state machine
  // ---------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    if (gnd_s)
      state_d = `ST_GNDLOSS;
    else if (prot_s && state_q != `ST_GNDLOSS)
      state_d = `ST_FAULT;
    else
    begin
      case (state_q)
        `ST_FAULT:
          // every cause gone, not latched, retry elapsed
          if (!latch_s && retry_done)
            state_d = en_s ? `ST_ACTIVE : `ST_STBY_DLY;
        `ST_GNDLOSS:
          state_d = `ST_STBY_DLY; // ground back, resume
        `ST_STBY_DLY:
          if (en_s)
            state_d = `ST_ACTIVE;
          else if (diag_s)
            state_d = `ST_DIAG;
          else if (stby_done)
            state_d = `ST_STBY;
        `ST_STBY, `ST_DIAG, `ST_ACTIVE:
          if (en_s)
            state_d = `ST_ACTIVE;
          else if (diag_s)
            state_d = `ST_DIAG;
          else if (state_q != `ST_STBY)
            state_d = `ST_STBY_DLY;
        default:
          state_d = `ST_STBY_DLY;
      endcase
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= `ST_STBY_DLY;
    else
      state_q <= state_d;
  end

  // ---------------------------------------------------------------
  // outputs from state
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      switch_on <= 1'b0;
      diag_active <= 1'b0;
      low_power <= 1'b0;
      sense_fault_level <= 1'b0;
    end
    else
    begin
      // on only in active and not tripped
      switch_on <= (state_d == `ST_ACTIVE) && !wd_trip_q && !prot_s;
      // diag may toggle within active
      diag_active <= diag_s && state_d != `ST_STBY;
      low_power <= (state_d == `ST_STBY);
      // sense mux shows the fault level only with select 00
      sense_fault_level <= diag_s && sel_s == 2'b00 &&
        (shut_flag_q || ilim_s || ol_flag_q);
    end
  end

  // open drain pin: shutdown any select, open load only at 00
  wire pin_fault = shut_flag_q || ilim_s ||
    (ol_flag_q && sel_s == 2'b00);
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_n_oe = pin_fault;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  reg aw_hold_q; // write address taken
  reg w_hold_q; // write data taken
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // byte-lane merge used by all writable registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  wire do_write = aw_hold_q && w_hold_q;

  // write channel: address and data in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_q <= `CTRL_RST;
      wd_to_q <= `WD_TIMEOUT_US;
      stby_q <= `STBY_DELAY_US;
      retry_q <= `RETRY_US;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (awaddr_q[3:2])
          2'h0: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h1;
          2'h2: wd_to_q <= merge(wd_to_q, wdata_q, wstrb_q);
          2'h3: stby_q <= merge(stby_q, wdata_q, wstrb_q);
          default: s_axi_bresp <= 2'b10; // status is read only
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one cycle answer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr[3:2])
        2'h0: s_axi_rdata <= ctrl_q;
        2'h1: s_axi_rdata <= {16'h0000, 2'b00, state_q, 3'b000,
          wd_trip_q, ol_flag_q, shut_flag_q, switch_on, en_s};
        2'h2: s_axi_rdata <= wd_to_q;
        default: s_axi_rdata <= stby_q;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // switch_ctrl

// >>> tb/switch_ctrl_assertions.sv
// switch_ctrl_assertions.sv: port timing checks of the switch control
// assumes a bind into switch_ctrl; one clock, sync active-low reset
`timescale 1ns/1ns
module switch_ctrl_assertions (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pins and sensing
  input wire enable_in,
  input wire diag_request,
  input wire [1:0] sense_select,
  input wire thermal_sd,
  input wire current_limit,
  input wire energy_limit,
  input wire gnd_lost,
  // outputs
  input wire switch_on,
  input wire diag_active,
  input wire low_power,
  input wire fault_flag_n_o,
  input wire fault_flag_n_oe,
  input wire sense_fault_level,
  // bus handshakes
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // pin histories, long enough for sync latency
  // ----------------------------------------
  sequence en_low_s; (!enable_in)[*6]; endsequence
  sequence shut_s; (thermal_sd || current_limit || energy_limit)[*4];
  endsequence
  en_low_off_a: assert property (en_low_s |-> !switch_on)
    else $error("switch on with enable low");
  on_cause_a: assert property ($rose(switch_on) |->
    $past(enable_in) && $past(enable_in, 2))
    else $error("switch rose without enable");
  shut_off_a: assert property (shut_s |-> !switch_on)
    else $error("switch on during shutdown");
  shut_flag_a: assert property (shut_s |-> fault_flag_n_oe)
    else $error("fault pin released during shutdown");
  gnd_off_a: assert property (gnd_lost[*4] |-> !switch_on)
    else $error("switch on with ground lost");
  low_pow_a: assert property (low_power |-> !diag_active && !switch_on)
    else $error("standby with diag or switch");
  diag_wake_a: assert property (diag_request[*6] |-> !low_power)
    else $error("standby with diag request");
  sel_mask_a: assert property ((sense_select != 2'b00)[*4]
    |-> !sense_fault_level)
    else $error("sense fault level with sel not 00");
  od_pull_a: assert property (fault_flag_n_oe |-> !fault_flag_n_o)
    else $error("fault pin driven high");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
endmodule // switch_ctrl_assertions

// >>> tb/host_mcu.sv
// host_mcu.sv: host controller model driving the switch pins
// assumes the bench calls its tasks right after a rising aclk edge
`timescale 1ns/1ns
module host_mcu (
  // clock
  input wire aclk,
  // pins toward the switch
  output logic enable_in,
  output logic diag_request,
  output logic latch_sel,
  output logic [1:0] sense_select,
  // open-drain fault pin
  input wire fault_flag_n_o,
  input wire fault_flag_n_oe,
  output wire fault_line
);
  // pull-up: a released pin reads high, never the last value
  assign fault_line = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  initial
  begin
    enable_in = 1'b0;
    diag_request = 1'b0;
    latch_sel = 1'b0;
    sense_select = 2'b00;
  end
  // level changes on all pins at once
  task automatic pins(input logic e, d, l, input logic [1:0] s);
    enable_in <= e;
    diag_request <= d;
    latch_sel <= l;
    sense_select <= s;
  endtask
  // low refresh pulse of 6 us, then hi cycles high
  task automatic refresh(input int hi);
    enable_in <= 1'b0;
    repeat (120) @(posedge aclk);
    enable_in <= 1'b1;
    repeat (hi) @(posedge aclk);
  endtask
endmodule // host_mcu

// >>> tb/switch_enable_watchdog_fsm_test.sv
// switch_enable_watchdog_fsm_test.sv: self-checking bench of switch_ctrl
// assumes host_mcu and switch_ctrl_assertions are compiled before it
`timescale 1ns/1ns
`include "switch_ctrl_map.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module switch_enable_watchdog_fsm_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, sense_select;
  logic thermal_sd = 0, current_limit = 0, energy_limit = 0;
  logic active_ilim = 0, open_load_det = 0, gnd_lost = 0;
  logic reverse_current = 0;
  logic enable_in, diag_request, latch_sel, fault_line;
  logic switch_on, diag_active, low_power, sense_fault_level;
  logic fault_flag_n_o, fault_flag_n_oe;
  int failures = 0, checked = 0, seed = 32'hb1a9771a;
  int wd_us = 30, sb_us = 5; // shortened timer settings
  always #25 aclk = ~aclk;
  // reverse current toggles at random; nothing may react
  always @(posedge aclk) reverse_current <= 1'($random(seed));
  switch_ctrl switch_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .enable_in(enable_in),
    .diag_request(diag_request), .latch_sel(latch_sel),
    .sense_select(sense_select), .thermal_sd(thermal_sd),
    .current_limit(current_limit), .energy_limit(energy_limit),
    .active_ilim(active_ilim), .open_load_det(open_load_det),
    .gnd_lost(gnd_lost), .reverse_current(reverse_current),
    .switch_on(switch_on), .diag_active(diag_active),
    .low_power(low_power), .fault_flag_n_o(fault_flag_n_o),
    .fault_flag_n_oe(fault_flag_n_oe),
    .sense_fault_level(sense_fault_level));
  host_mcu host_mcu_i (.aclk(aclk), .enable_in(enable_in),
    .diag_request(diag_request), .latch_sel(latch_sel),
    .sense_select(sense_select), .fault_flag_n_o(fault_flag_n_o),
    .fault_flag_n_oe(fault_flag_n_oe), .fault_line(fault_line));
  // ----------------------------------------
  // bus tasks: decide at negedge, act at posedge
  // ----------------------------------------
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ta, tw, t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      t = s_axi_bvalid;
      if (t) `CHK("bresp", er, s_axi_bresp)
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (t) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ta, t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      t = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (t) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic st(input logic [5:0] e);
    logic [31:0] v;
    rd(4'h4, v);
    `CHK("state", e, v[13:8])
  endtask
  task automatic flag(input int b, input logic e);
    logic [31:0] v;
    rd(4'h4, v);
    `CHK("status bit", e, v[b])
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard: whole run needs about 70k cycles
  initial
  begin
    cyc(90000);
    failures++;
    end_sim;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    cyc(6);
    aresetn <= 1'b1;
    rd(4'h0, r);
    `CHK("wd_variant", 1'b1, r[0]);
    rd(4'h8, r);
    `CHK("wd_timeout", `WD_TIMEOUT_US, r);
    rd(4'hc, r);
    `CHK("stby_delay", `STBY_DELAY_US, r);
    axw(4'h4, 32'h0, 2'b10);
    axw(4'h8, wd_us, 2'b00);
    axw(4'hc, sb_us, 2'b00);
    rd(4'h8, r);
    `CHK("wd_timeout", wd_us, r);
    host_mcu_i.pins(0, 1, 0, 2'b00);
    cyc(8);
    st(`ST_DIAG);
    `CHK("switch_on", 1'b0, switch_on);
    `CHK("diag_active", 1'b1, diag_active);
    host_mcu_i.pins(0, 0, 0, 2'b00);
    cyc(8);
    st(`ST_STBY_DLY);
    cyc(sb_us * 20 - 40);
    st(`ST_STBY_DLY);
    cyc(80);
    st(`ST_STBY);
    `CHK("low_power", 1'b1, low_power);
    host_mcu_i.pins(0, 1, 0, 2'b00);
    open_load_det <= 1'b1;
    cyc(8);
    `CHK("sense_fault", 1'b1, sense_fault_level);
    `CHK("fault_line", 1'b0, fault_line);
    host_mcu_i.pins(0, 1, 0, 2'b10);
    cyc(8);
    `CHK("sense_fault", 1'b0, sense_fault_level);
    host_mcu_i.pins(0, 1, 0, 2'b00);
    open_load_det <= 1'b0;
    cyc(8);
    flag(3, 1'b0);
    open_load_det <= 1'b1;
    cyc(8);
    flag(3, 1'b1);
    host_mcu_i.pins(1, 1, 0, 2'b00);
    cyc(8);
    flag(3, 1'b0);
    open_load_det <= 1'b0;
    host_mcu_i.pins(1, 0, 0, 2'b00);
    cyc(8);
    st(`ST_ACTIVE);
    `CHK("diag_active", 1'b0, diag_active);
    repeat (4) host_mcu_i.refresh(280);
    `CHK("switch_on", 1'b1, switch_on);
    cyc((wd_us - 18) * 20);
    `CHK("switch_on", 1'b1, switch_on);
    cyc(200);
    `CHK("switch_on", 1'b0, switch_on);
    flag(4, 1'b1);
    host_mcu_i.pins(0, 0, 0, 2'b00);
    cyc(8);
    flag(4, 1'b0);
    host_mcu_i.pins(1, 0, 0, 2'b00);
    cyc(8);
    gnd_lost <= 1'b1;
    cyc(8);
    `CHK("switch_on", 1'b0, switch_on);
    st(`ST_GNDLOSS);
    gnd_lost <= 1'b0;
    cyc((sb_us + 3) * 20);
    `CHK("switch_on", 1'b1, switch_on);
    active_ilim <= 1'b1;
    cyc(8);
    `CHK("fault_line", 1'b0, fault_line);
    active_ilim <= 1'b0;
    axw(4'h0, 32'h0, 2'b00);
    cyc((wd_us + 10) * 20);
    `CHK("switch_on", 1'b1, switch_on);
    // each shutdown cause; first one latched, last with enable low
    for (int i = 0; i < 3; i++)
    begin
      host_mcu_i.pins(1, 0, i == 0, 2'b00);
      {thermal_sd, current_limit, energy_limit} <= 3'b100 >> i;
      cyc(8);
      st(`ST_FAULT);
      `CHK("fault_line", 1'b0, fault_line);
      {thermal_sd, current_limit, energy_limit} <= 3'b000;
      if (i == 2) host_mcu_i.pins(0, 0, 0, 2'b00);
      cyc(19000);
      st(`ST_FAULT);
      cyc(2000);
      if (i == 0)
      begin
        st(`ST_FAULT);
        host_mcu_i.pins(1, 0, 0, 2'b00);
        cyc(8);
      end
      `CHK("switch_on", i != 2, switch_on);
    end
    end_sim;
  end
endmodule // switch_enable_watchdog_fsm_test
bind switch_ctrl switch_ctrl_assertions switch_ctrl_assertions_i (.*);
